// ==== hdl/decode_if.sv ====
/*
 Carrier between the glue top and its address decoder.
 Assumes a purely combinational decoder on the far modport.
*/
`timescale 1ns/1ps
interface decode_if;
  logic [15:0] addr;
  periph_map_pkg::periph_id_t id;
  logic [2:0] inst;
  logic hit;

  modport requester (output addr, input id, input inst, input hit);
  modport decoder (input addr, output id, output inst, output hit);
endinterface : decode_if

// ==== hdl/periph_decode_irq_vector_map.sv ====
/*
 System glue: peripheral select decode, interrupt flags/enables, vector mapping.
 Assumes event, clear and enable-write strobes come from logic on ref_clk_i.
*/
`timescale 1ns/1ps
`include "periph_map_regs.svh"
module periph_decode_irq_vector_map #(
  parameter bit LARGE_PACKAGE = 1'b1,
  parameter int NUM_SRC = 4
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic cpu_access_i,
  input wire logic [15:0] cpu_addr_i,
  output periph_map_pkg::periph_id_t periph_sel_o,
  output logic [2:0] periph_inst_o,
  output logic periph_hit_o,
  input wire logic [NUM_SRC-1:0] src_event_i,
  input wire logic [NUM_SRC-1:0] flag_clear_i,
  input wire logic enable_wr_i,
  input wire logic [NUM_SRC-1:0] enable_data_i,
  input wire logic global_int_en_i,
  output logic [NUM_SRC-1:0] flags_o,
  output logic [NUM_SRC-1:0] enables_o,
  output logic [3:1] irq_vec_o,
  output logic pending_o,
  output logic [4:0] vector_num_o,
  output logic [7:0] vector_addr_o,
  output logic reset_entry_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode, registered towards the peripherals
  decode_if dec_bus ();
  periph_map_pkg::periph_id_t sel_q;
  logic [2:0] inst_q;
  logic hit_q;

  assign dec_bus.addr = cpu_addr_i;

  peripheral_address_decoder #(
    .LARGE_PACKAGE(LARGE_PACKAGE)
  ) u_decoder (
    .dec(dec_bus)
  );

  // Select stands one cycle after the access, idle when no access
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || !cpu_access_i)
    begin
      sel_q <= periph_map_pkg::PERIPH_NONE;
      inst_q <= 3'h0;
      hit_q <= 1'b0;
    end
    else
    begin
      sel_q <= dec_bus.id;
      inst_q <= dec_bus.inst;
      hit_q <= dec_bus.hit;
    end
  end

  assign periph_sel_o = sel_q;
  assign periph_inst_o = inst_q;
  assign periph_hit_o = hit_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Flag and enable bits, one cell per source
  logic [NUM_SRC-1:0] flags_q;
  logic [NUM_SRC-1:0] enables_q;
  logic [NUM_SRC-1:0] src_req;

  for (genvar i = 0; i < NUM_SRC; i++)
  begin : g_src
    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i)
    begin
      if (sys_rst_i)
        flags_q[i] <= 1'b0;
      else
        flags_q[i] <= src_event_i[i] | (flags_q[i] & ~flag_clear_i[i]);
    end

    // Software-written enable bit
    always_ff @(posedge ref_clk_i)
    begin
      if (sys_rst_i)
        enables_q[i] <= 1'b0;
      else if (enable_wr_i)
        enables_q[i] <= enable_data_i[i];
    end

    assign src_req[i] = flags_q[i] & enables_q[i];
  end

  assign flags_o = flags_q;
  assign enables_o = enables_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-vector requests; only the scanner vector bypasses the global enable
  assign irq_vec_o[1] = src_req[periph_map_pkg::SRC_SCAN];
  assign irq_vec_o[2] = src_req[periph_map_pkg::SRC_VLM] & global_int_en_i;
  assign irq_vec_o[3] = (src_req[periph_map_pkg::SRC_RTC_OVF]
                        | src_req[periph_map_pkg::SRC_RTC_CMP]) & global_int_en_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Start-up: one cycle presenting the reset entry
  periph_map_pkg::run_state_t state_q;

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      state_q <= periph_map_pkg::ST_BOOT;
    else
    begin
      case (state_q)
        periph_map_pkg::ST_BOOT: state_q <= periph_map_pkg::ST_RUN;
        periph_map_pkg::ST_RUN: state_q <= periph_map_pkg::ST_RUN;
        default: state_q <= periph_map_pkg::ST_BOOT;
      endcase
    end
  end

  assign reset_entry_o = (state_q == periph_map_pkg::ST_BOOT);

  ////////////////////////////////////////////////////////////////////////////////
  // Vector number and word address, lowest number first
  logic [4:0] vec_d;
  logic pend_d;
  logic [4:0] vec_q;
  logic pend_q;

  always_comb
  begin
    pend_d = 1'b1;
    vec_d = `VEC_NUM_RESET;
    if (state_q == periph_map_pkg::ST_BOOT)
      vec_d = `VEC_NUM_RESET;
    else if (irq_vec_o[1])
      vec_d = `VEC_NUM_SCAN;
    else if (irq_vec_o[2])
      vec_d = `VEC_NUM_VLM;
    else if (irq_vec_o[3])
      vec_d = `VEC_NUM_RTC;
    else
      pend_d = 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      vec_q <= `VEC_NUM_RESET;
      pend_q <= 1'b0;
    end
    else
    begin
      vec_q <= vec_d;
      pend_q <= pend_d;
    end
  end

  assign pending_o = pend_q;
  assign vector_num_o = vec_q;
  assign vector_addr_o = {2'b00, vec_q, 1'b0};

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_vlm_alone;
    irq_vec_o == 3'b010;
  endsequence

  sequence s_rtc_alone;
    irq_vec_o == 3'b100;
  endsequence

  a_flag_set: assert property (src_event_i[1] |=> flags_o[1])
    else $error("event did not set its flag");
  a_enable_write: assert property (enable_wr_i |=> enables_o == $past(enable_data_i))
    else $error("enable bits not written");
  a_req_needs_both: assert property (irq_vec_o[2] |-> flags_o[1] && enables_o[1])
    else $error("request without flag and enable");
  a_req_holds: assert property (irq_vec_o[2] && !flag_clear_i[1] && !enable_wr_i
                                |=> irq_vec_o[2] || !global_int_en_i)
    else $error("request dropped without clear");
  a_global_gate: assert property (!global_int_en_i |-> irq_vec_o[3:2] == 2'b00)
    else $error("maskable request while globally disabled");
  a_rtc_merge: assert property (global_int_en_i && enables_o[3] && flags_o[3]
                                |-> irq_vec_o[3])
    else $error("compare source not merged onto its vector");
  a_nmi_ungated: assert property (flags_o[0] && enables_o[0] && !global_int_en_i
                                  |-> irq_vec_o[1])
    else $error("scanner vector gated by global enable");
  a_vlm_vector: assert property (s_vlm_alone ##1 state_q == periph_map_pkg::ST_RUN
                                 |-> vector_addr_o == `VEC_ADDR_VLM)
    else $error("wrong vector for level monitor");
  a_rtc_vector: assert property (s_rtc_alone |=> vector_num_o == `VEC_NUM_RTC
                                 && vector_addr_o == `VEC_ADDR_RTC)
    else $error("wrong vector for real-time counter");
  a_vport_slot: assert property (cpu_access_i && cpu_addr_i == `VPORT_LAST
                                 |=> periph_sel_o == periph_map_pkg::PERIPH_VPORT
                                 && periph_inst_o == 3'h5)
    else $error("last virtual port slot misdecoded");
  a_gpio_decode: assert property (cpu_access_i && cpu_addr_i == `GPIO_BASE
                                  |=> periph_sel_o == periph_map_pkg::PERIPH_GPIO)
    else $error("scratch registers misdecoded");
  a_scan_decode: assert property (cpu_access_i && cpu_addr_i == `SCAN_BASE
                                  |=> periph_sel_o == periph_map_pkg::PERIPH_SCAN)
    else $error("scanner misdecoded");
  a_usart_last: assert property (cpu_access_i && cpu_addr_i == `USART_LAST
                                 |=> periph_inst_o == 3'h3 && periph_hit_o == LARGE_PACKAGE)
    else $error("fourth transceiver misdecoded");
  a_tca_decode: assert property (cpu_access_i && cpu_addr_i == `TCA_BASE
                                 |=> periph_sel_o == periph_map_pkg::PERIPH_TCA)
    else $error("first-type timer misdecoded");
  a_tcb_last: assert property (cpu_access_i && cpu_addr_i == `TCB_LAST
                               |=> periph_inst_o == 3'h3 && periph_hit_o == LARGE_PACKAGE)
    else $error("fourth second-type timer misdecoded");
  a_reset_entry: assert property ($past(sys_rst_i) |-> reset_entry_o ##1
                                  vector_num_o == `VEC_NUM_RESET && pending_o)
    else $error("reset entry not presented");

endmodule : periph_decode_irq_vector_map

// ==== hdl/periph_map_pkg.sv ====
/*
 Types shared by the address decoder and the interrupt glue.
 Assumes nothing beyond a SystemVerilog elaborator.
*/
package periph_map_pkg;

  // Peripheral groups that the decoder can select
  typedef enum logic [3:0] {
    PERIPH_NONE = 4'h0,
    PERIPH_VPORT = 4'h1,
    PERIPH_GPIO = 4'h2,
    PERIPH_SCAN = 4'h3,
    PERIPH_USART = 4'h4,
    PERIPH_TCA = 4'h5,
    PERIPH_TCB = 4'h6
  } periph_id_t;

  // Interrupt source index into flag and enable vectors
  typedef enum logic [1:0] {
    SRC_SCAN = 2'h0,
    SRC_VLM = 2'h1,
    SRC_RTC_OVF = 2'h2,
    SRC_RTC_CMP = 2'h3
  } irq_src_t;

  // Start-up sequencing
  typedef enum logic {
    ST_BOOT = 1'b0,
    ST_RUN = 1'b1
  } run_state_t;

endpackage : periph_map_pkg

// ==== hdl/periph_map_regs.svh ====
/*
 Address map, vector numbers and vector word addresses for the system glue block.
 Assumes a 16-bit data-space address from the processor core and 2-word vector slots.
*/
`ifndef PERIPH_MAP_REGS_SVH
`define PERIPH_MAP_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Peripheral bases and window sizes
`define VPORT_BASE 16'h0000
`define VPORT_STEP 16'h0004
`define VPORT_LAST 16'h0014
`define GPIO_BASE 16'h001C
`define GPIO_SIZE 16'h0004
`define SCAN_BASE 16'h0120
`define SCAN_SIZE 16'h0020
`define USART_BASE 16'h0800
`define USART_STEP 16'h0020
`define USART_LAST 16'h0860
`define TCA_BASE 16'h0A00
`define TCA_SIZE 16'h0080
`define TCB_BASE 16'h0A80
`define TCB_STEP 16'h0010
`define TCB_LAST 16'h0AB0

////////////////////////////////////////////////////////////////////////////////
// Vector numbers and program word addresses
`define VEC_NUM_RESET 5'h00
`define VEC_NUM_SCAN 5'h01
`define VEC_NUM_VLM 5'h02
`define VEC_NUM_RTC 5'h03
`define VEC_ADDR_RESET 8'h00
`define VEC_ADDR_SCAN 8'h02
`define VEC_ADDR_VLM 8'h04
`define VEC_ADDR_RTC 8'h06

`endif

// ==== hdl/peripheral_address_decoder.sv ====
/*
 Combinational base-address decoder for the peripheral map.
 Assumes the caller registers the result; absent instances on small packages miss.
*/
`timescale 1ns/1ps
`include "periph_map_regs.svh"
module peripheral_address_decoder #(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  decode_if.decoder dec
);

  // True when the address falls in [base, base+size)
  function automatic logic in_window(input logic [15:0] a, input logic [15:0] base,
                                     input logic [15:0] size);
    in_window = (a >= base) && (a < 16'(base + size));
  endfunction : in_window

  ////////////////////////////////////////////////////////////////////////////////
  // Window match, instance index and package gating
  always_comb
  begin
    dec.id = periph_map_pkg::PERIPH_NONE;
    dec.inst = 3'h0;
    dec.hit = 1'b0;
    if (in_window(dec.addr, `VPORT_BASE, 16'(`VPORT_LAST + `VPORT_STEP)))
    begin
      dec.id = periph_map_pkg::PERIPH_VPORT;
      dec.inst = dec.addr[4:2];
      dec.hit = LARGE_PACKAGE || ((dec.addr[4:2] != 3'h1) && (dec.addr[4:2] != 3'h4));
    end
    else if (in_window(dec.addr, `GPIO_BASE, `GPIO_SIZE))
    begin
      dec.id = periph_map_pkg::PERIPH_GPIO;
      dec.inst = {1'b0, dec.addr[1:0]};
      dec.hit = 1'b1;
    end
    else if (in_window(dec.addr, `SCAN_BASE, `SCAN_SIZE))
    begin
      dec.id = periph_map_pkg::PERIPH_SCAN;
      dec.hit = 1'b1;
    end
    else if (in_window(dec.addr, `USART_BASE, 16'(`USART_LAST + `USART_STEP - `USART_BASE)))
    begin
      dec.id = periph_map_pkg::PERIPH_USART;
      dec.inst = {1'b0, dec.addr[6:5]};
      dec.hit = LARGE_PACKAGE || (dec.addr[6:5] != 2'h3);
    end
    else if (in_window(dec.addr, `TCA_BASE, `TCA_SIZE))
    begin
      dec.id = periph_map_pkg::PERIPH_TCA;
      dec.hit = 1'b1;
    end
    else if (in_window(dec.addr, `TCB_BASE, 16'(`TCB_LAST + `TCB_STEP - `TCB_BASE)))
    begin
      dec.id = periph_map_pkg::PERIPH_TCB;
      dec.inst = {1'b0, dec.addr[5:4]};
      dec.hit = LARGE_PACKAGE || (dec.addr[5:4] != 2'h3);
    end
  end

endmodule : peripheral_address_decoder

// ==== testbench/core_model.sv ====
/*
 Processor core model: issues data-space accesses and holds the global interrupt enable.
 Assumes the glue answers a decode in the cycle after the access edge.
*/
`timescale 1ns/1ps
module core_model (
  input wire logic ref_clk_i,
  output logic cpu_access_o,
  output logic [15:0] cpu_addr_o,
  output logic gie_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus idle at time zero
  initial
  begin
    cpu_access_o = 1'b0;
    cpu_addr_o = 16'hFFFF;
    gie_o = 1'b0;
  end

  // One access cycle; a released address is scrambled so stale values never match
  task automatic access(input logic [15:0] a);
    @(negedge ref_clk_i);
    cpu_access_o = 1'b1;
    cpu_addr_o = a;
    @(negedge ref_clk_i);
    cpu_access_o = 1'b0;
    cpu_addr_o = ~a;
  endtask : access

  // Global enable level as the core's status bit would drive it
  task automatic set_gie(input logic v);
    @(negedge ref_clk_i);
    gie_o = v;
  endtask : set_gie
endmodule : core_model

// ==== testbench/periph_decode_irq_vector_map_tb.sv ====
/*
 Self-checking bench for the decode and interrupt glue.
 Assumes the core model drives bus and global enable; bench drives peripheral strobes.
*/
`timescale 1ns/1ps
module periph_decode_irq_vector_map_tb;
  typedef struct {logic [15:0] a; periph_map_pkg::periph_id_t id; logic [2:0] n; logic h;} dec_t;
  logic ref_clk_i;
  logic sys_rst_i;
  logic cpu_access;
  logic [15:0] cpu_addr;
  logic gie;
  logic [3:0] src_event;
  logic [3:0] flag_clear;
  logic enable_wr;
  logic [3:0] enable_data;
  periph_map_pkg::periph_id_t sel;
  logic [2:0] inst;
  logic hit;
  logic [3:0] flags;
  logic [3:0] enables;
  logic [3:1] irq;
  logic pending;
  logic [4:0] vnum;
  logic [7:0] vaddr;
  logic rentry;
  logic hit_small;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and core model
  periph_decode_irq_vector_map i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .cpu_access_i(cpu_access), .cpu_addr_i(cpu_addr), .periph_sel_o(sel),
    .periph_inst_o(inst), .periph_hit_o(hit), .src_event_i(src_event),
    .flag_clear_i(flag_clear), .enable_wr_i(enable_wr), .enable_data_i(enable_data),
    .global_int_en_i(gie), .flags_o(flags), .enables_o(enables), .irq_vec_o(irq),
    .pending_o(pending), .vector_num_o(vnum), .vector_addr_o(vaddr), .reset_entry_o(rentry));
  core_model i_core (.ref_clk_i(ref_clk_i), .cpu_access_o(cpu_access), .cpu_addr_o(cpu_addr),
    .gie_o(gie));

  // Small-package variant on the same stimulus, watched for absent instances
  periph_decode_irq_vector_map #(.LARGE_PACKAGE(1'b0)) i_dut_small (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .cpu_access_i(cpu_access), .cpu_addr_i(cpu_addr), .periph_sel_o(),
    .periph_inst_o(), .periph_hit_o(hit_small), .src_event_i(src_event),
    .flag_clear_i(flag_clear), .enable_wr_i(enable_wr), .enable_data_i(enable_data),
    .global_int_en_i(gie), .flags_o(), .enables_o(), .irq_vec_o(), .pending_o(),
    .vector_num_o(), .vector_addr_o(), .reset_entry_o());

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      print_verdict();
    end
  end

  // Compare and report
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One strobe cycle: 0 event, 1 clear, else enable write
  task automatic pulse(input int k, input logic [3:0] v);
    @(negedge ref_clk_i);
    if (k == 0) src_event = v;
    else if (k == 1) flag_clear = v;
    else
    begin
      enable_wr = 1'b1;
      enable_data = v;
    end
    @(negedge ref_clk_i);
    src_event = 4'h0;
    flag_clear = 4'h0;
    enable_wr = 1'b0;
  endtask : pulse

  // Vector presented one cycle later at word 2n
  task automatic vec_chk(input logic [4:0] n);
    @(negedge ref_clk_i);
    chk("pending", 16'h0001, {15'h0000, pending});
    chk("vector_num", {11'h000, n}, {11'h000, vnum});
    chk("vector_addr", {7'h00, n, 4'h0} >> 3, {8'h00, vaddr});
  endtask : vec_chk

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release presents the reset entry
  task automatic t_reset;
    chk("reset_entry", 16'h0001, {15'h0000, rentry});
    chk("flags", 16'h0000, {12'h000, flags});
    chk("enables", 16'h0000, {12'h000, enables});
    vec_chk(5'h00);
    chk("reset_entry", 16'h0000, {15'h0000, rentry});
    $display("test reset done");
  endtask : t_reset

  // Base address table, boundaries and misses
  task automatic t_decode;
    dec_t tbl [16];
    logic small_h;
    tbl = '{
      '{16'h0000, periph_map_pkg::PERIPH_VPORT, 0, 1},
      '{16'h0004, periph_map_pkg::PERIPH_VPORT, 1, 1},
      '{16'h0010, periph_map_pkg::PERIPH_VPORT, 4, 1},
      '{16'h0014, periph_map_pkg::PERIPH_VPORT, 5, 1},
      '{16'h0017, periph_map_pkg::PERIPH_VPORT, 5, 1},
      '{16'h0018, periph_map_pkg::PERIPH_NONE, 0, 0},
      '{16'h001C, periph_map_pkg::PERIPH_GPIO, 0, 1},
      '{16'h001F, periph_map_pkg::PERIPH_GPIO, 3, 1},
      '{16'h0120, periph_map_pkg::PERIPH_SCAN, 0, 1},
      '{16'h0110, periph_map_pkg::PERIPH_NONE, 0, 0},
      '{16'h0800, periph_map_pkg::PERIPH_USART, 0, 1},
      '{16'h0860, periph_map_pkg::PERIPH_USART, 3, 1},
      '{16'h0A00, periph_map_pkg::PERIPH_TCA, 0, 1},
      '{16'h0A90, periph_map_pkg::PERIPH_TCB, 1, 1},
      '{16'h0AB0, periph_map_pkg::PERIPH_TCB, 3, 1},
      '{16'h0AC0, periph_map_pkg::PERIPH_NONE, 0, 0}};
    foreach (tbl[i])
    begin
      i_core.access(tbl[i].a);
      small_h = tbl[i].h && !(tbl[i].a inside {16'h0004, 16'h0010, 16'h0860, 16'h0AB0});
      chk("periph_sel", 16'(tbl[i].id), 16'(sel));
      chk("periph_hit", {15'h0000, tbl[i].h}, {15'h0000, hit});
      chk("hit_small", 16'(small_h), 16'(hit_small));
      if (tbl[i].h && tbl[i].id != periph_map_pkg::PERIPH_SCAN
          && tbl[i].id != periph_map_pkg::PERIPH_TCA)
        chk("periph_inst", {13'h0000, tbl[i].n}, {13'h0000, inst});
    end
    @(negedge ref_clk_i);
    chk("periph_sel idle", 16'h0000, {12'h000, sel});
    $display("test decode done");
  endtask : t_decode

  // Flags, enables, global gating and vector mapping
  task automatic t_irq;
    i_core.set_gie(1'b1);
    pulse(0, 4'hF);
    chk("flags", 16'h000F, {12'h000, flags});
    chk("irq_vec", 16'h0000, {13'h0000, irq});
    pulse(2, 4'h2);
    chk("enables", 16'h0002, {12'h000, enables});
    chk("irq_vec", 16'h0002, {13'h0000, irq});
    vec_chk(5'h02);
    i_core.set_gie(1'b0);
    #1 chk("irq_vec", 16'h0000, {13'h0000, irq});
    @(negedge ref_clk_i);
    chk("pending", 16'h0000, {15'h0000, pending});
    pulse(2, 4'h1);
    chk("irq_vec", 16'h0001, {13'h0000, irq});
    vec_chk(5'h01);
    repeat (3) @(negedge ref_clk_i);
    chk("irq_vec", 16'h0001, {13'h0000, irq});
    pulse(1, 4'h1);
    chk("flags", 16'h000E, {12'h000, flags});
    chk("irq_vec", 16'h0000, {13'h0000, irq});
    i_core.set_gie(1'b1);
    pulse(2, 4'h8);
    chk("irq_vec", 16'h0004, {13'h0000, irq});
    vec_chk(5'h03);
    pulse(1, 4'h8);
    pulse(2, 4'h4);
    chk("irq_vec", 16'h0004, {13'h0000, irq});
    pulse(2, 4'h7);
    pulse(0, 4'h1);
    chk("irq_vec", 16'h0007, {13'h0000, irq});
    vec_chk(5'h01);
    $display("test irq done");
  endtask : t_irq

  // Mid-run reset clears flags and enables and presents the reset entry again
  task automatic t_rerun;
    @(negedge ref_clk_i);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    chk("irq_vec", 16'h0000, {13'h0000, irq});
    t_reset();
    $display("test rerun done");
  endtask : t_rerun

  // Event and clear in one cycle: the set wins
  task automatic t_set_wins;
    @(negedge ref_clk_i);
    src_event = 4'h2;
    flag_clear = 4'h2;
    @(negedge ref_clk_i);
    src_event = 4'h0;
    flag_clear = 4'h0;
    chk("flags", 16'h0002, {12'h000, flags});
    $display("test set_wins done");
  endtask : t_set_wins

  // Closing report
  task automatic print_verdict;
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    sys_rst_i = 1'b1;
    src_event = 4'h0;
    flag_clear = 4'h0;
    enable_wr = 1'b0;
    enable_data = 4'h0;
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_decode();
    t_irq();
    t_rerun();
    t_set_wins();
    print_verdict();
  end
endmodule : periph_decode_irq_vector_map_tb
